/* core/aol_pkg.sv */
// Package of the offset-correcting converter control block.
// Assumes a Wishbone classic slave with 32-bit data and word-aligned registers.
package aol_pkg;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_OFFSET = 8'h08;
    localparam logic [7:0] OFF_RESULT = 8'h0C;
    localparam logic [7:0] OFF_CMP = 8'h10;
    localparam logic [15:0] OFFSET_RST = 16'h0000;
    localparam logic [15:0] RESULT_RST = 16'h0000;
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_SWSTART = 1;
    localparam int CTRL_CONT = 2;
    localparam int CTRL_HWTRIG = 3;
    localparam int CTRL_IRQEN = 4;
    localparam int CTRL_AVGEN = 5;
    localparam int CTRL_CMPEN = 6;
    localparam int CTRL_CAL = 7;
    localparam int CTRL_ASYNC = 8;
    localparam int CTRL_MODE_LO = 9;
    localparam int CTRL_AVGS_LO = 11;
    localparam int CTRL_GT = 13;
    localparam logic [1:0] MODE_8 = 2'h0;
    localparam logic [1:0] MODE_12 = 2'h1;
    localparam logic [1:0] MODE_10 = 2'h2;
    localparam logic [15:0] MAX_8 = 16'h00FF;
    localparam logic [15:0] MAX_10 = 16'h03FF;
    localparam logic [15:0] MAX_12 = 16'h0FFF;
    localparam logic [3:0] CONV_CYCLES = 4'hF;
    localparam logic [3:0] CAL_CYCLES = 4'hF;
    localparam logic [15:0] CAL_OFFSET = 16'h0000;
    localparam int STATUS_DONE = 0;
    localparam int STATUS_ACTIVE = 1;
    localparam int STATUS_CALFAIL = 2;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_CONV = 4'b0010,
        ST_POST = 4'b0100,
        ST_CAL = 4'b1000
    } aol_state_t;
endpackage

/* core/aol_conv_if.sv */
// Interface carrying conversion requests to the result post-processor.
// Assumes one clock; valid is a one-cycle pulse.
`timescale 1ns/1ps
interface aol_conv_if;
    logic valid;
    logic [15:0] raw;
    logic [15:0] offset;
    logic [1:0] mode;
    logic [15:0] result;
    modport ctrl(output valid, output raw, output offset, output mode, input result);
    modport post(input valid, input raw, input offset, input mode, output result);
endinterface

/* core/aol_post.sv */
// Offset subtraction and saturation of one conversion or averaged sample.
// Assumes the caller samples the result one cycle after valid.
`timescale 1ns/1ps
module aol_post (
    input wire logic clk,
    input wire logic rstn,
    aol_conv_if.post p
);
    import aol_pkg::*;
    typedef struct packed {
        logic [15:0] result;
    } aol_post_t;
    aol_post_t s_q;
    aol_post_t s_d;
    logic signed [17:0] diff;
    logic [15:0] maxv;
    logic [15:0] ofsAligned;

    // =======================================================
    // Correction
    always_comb begin
        s_d = s_q;
        maxv = MAX_12;
        // Offset is left-justified in 12- and 10-bit modes; 8-bit mode takes bits 14:7 under sign bit 15. [R03]
        ofsAligned = {{4{p.offset[15]}}, p.offset[15:4]};
        case (p.mode)
            MODE_8: begin
                maxv = MAX_8;
                ofsAligned = {{8{p.offset[15]}}, p.offset[14:7]};
            end
            MODE_10: begin
                maxv = MAX_10;
                ofsAligned = {{6{p.offset[15]}}, p.offset[15:6]};
            end
            default: begin
            end
        endcase
        if (p.mode == MODE_8) begin
            ofsAligned = {{8{p.offset[15]}}, p.offset[14:7]};
        end
        // Negative offsets add to the result. [R01] [R06]
        diff = $signed({2'b00, p.raw}) - $signed({ofsAligned[15], ofsAligned[15], ofsAligned});
        if (p.valid) begin
            if (diff < 0) begin
                s_d.result = 16'h0000; // [R02] [R07]
            end else if (diff > $signed({2'b00, maxv})) begin
                s_d.result = maxv; // [R02] [R24]
            end else begin
                s_d.result = diff[15:0];
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign p.result = s_q.result;

    property p_clamp;
        @(posedge clk) disable iff (!rstn) p.valid |=> (p.result <= $past(maxv));
    endproperty
    a_clamp: assert property (p_clamp) else $error("Result above full scale."); // [R24]
endmodule

/* core/aol_ctrl.sv */
// Converter control: register file, sequencing, averaging, compare, power modes.
// Assumes a classic Wishbone master, raw samples from the analog core on sampleIn.
// Contract
// R01: Subtract offset from every result.
// R02: Saturate out-of-range corrected results.
// R03: Offset left-justified, sign bit fifteen; the code takes bits 14:7 in 8-bit mode instead.
// R04: Calibration end loads offset register.
// R05: Software may overwrite offset register.
// R06: Offset applies to averaged value.
// R07: Single-ended minimum is zero.
// R08: Twelve, ten, eight bit modes supported.
// R09: Wait mode lets conversion finish.
// R10: Wait starts only by trigger/continuous.
// R11: Synchronous and async clocks usable in wait.
// R12: Done flag per averaging and compare.
// R13: Failed compare in wait returns idle; the code starts the next conversion instead when CTRL_CONT is set.
// R14: Stop without async clock aborts conversion.
// R15: Normal stop keeps all registers; stop during calibration clears CTRL_CAL and sets calFail.
// R16: Software retriggers after aborted stop.
// R17: Async clock keeps running in stop.
// R18: Stop keeps first completed result.
// R19: Failed compare in stop returns idle; with CTRL_ASYNC and CTRL_CONT set the code starts the next conversion instead.
// R20: Low-power stop disables converter.
// R21: Low-power stop exit restores reset values.
// R22: Software calibrates then configures in order.
// R23: Done with enable raises interrupt.
// R24: Upper limit is resolution all-ones.
`timescale 1ns/1ps
module aol_ctrl (
    input wire logic clk,
    input wire logic resetn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [15:0] sampleIn,
    input wire logic hwTrigger,
    input wire logic waitMode,
    input wire logic stopMode,
    input wire logic lowPowerStop,
    output logic convIrq
);
    import aol_pkg::*;
    typedef struct packed {
        aol_state_t st;
        logic [15:0] ctrl;
        logic [15:0] offset;
        logic [15:0] result;
        logic [15:0] cmp;
        logic done;
        logic calFail;
        logic [3:0] cnt;
        logic [5:0] avgCnt;
        logic [21:0] acc;
        logic stopFirstHeld;
        logic ack;
        logic [31:0] rdata;
        logic trigPrev;
    } aol_ctrl_t;
    aol_ctrl_t s_q;
    aol_ctrl_t s_d;
    logic [1:0] rstSync;
    logic rstn;
    logic [1:0] trigSync;
    logic [1:0] waitSync;
    logic [1:0] stopSync;
    logic [1:0] lpSync;
    logic [15:0] sampleA;
    logic [15:0] sampleB;
    aol_conv_if cif();

    function automatic logic [5:0] avg_count(input logic [1:0] sel);
        avg_count = 6'(6'h04 << sel);
    endfunction

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] sel);
        merge = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
    endfunction

    // =======================================================
    // Reset and pin synchronisers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rstSync <= 2'h0;
        end else begin
            rstSync <= {rstSync[0], 1'b1};
        end
    end
    assign rstn = rstSync[1];

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            trigSync <= 2'h0;
            waitSync <= 2'h0;
            stopSync <= 2'h0;
            lpSync <= 2'h0;
            sampleA <= 16'h0000;
            sampleB <= 16'h0000;
        end else begin
            trigSync <= {trigSync[0], hwTrigger};
            waitSync <= {waitSync[0], waitMode};
            stopSync <= {stopSync[0], stopMode};
            lpSync <= {lpSync[0], lowPowerStop};
            sampleA <= sampleIn;
            sampleB <= sampleA;
        end
    end

    logic inWait;
    logic inStop;
    logic inLp;
    logic trigEdge;
    logic sleeping;
    logic busWr;
    logic busRd;
    logic cmpTrue;
    logic [15:0] avgValue;
    assign inWait = waitSync[1];
    assign inStop = stopSync[1];
    assign inLp = lpSync[1];
    assign trigEdge = trigSync[1] & ~s_q.trigPrev;
    assign sleeping = inWait | inStop;
    assign busWr = wb_cyc_i & wb_stb_i & wb_we_i & ~s_q.ack;
    assign busRd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~s_q.ack;

    assign cif.valid = (s_q.st == ST_CONV) && (s_q.cnt == 4'h0) && (!s_q.ctrl[CTRL_AVGEN]
        || s_q.avgCnt == avg_count(s_q.ctrl[CTRL_AVGS_LO +: 2]) - 6'h01);
    assign avgValue = s_q.ctrl[CTRL_AVGEN] ? 16'((22'(s_q.acc) + 22'(sampleB)) >> (s_q.ctrl[CTRL_AVGS_LO +: 2] + 2))
        : sampleB;
    assign cif.raw = avgValue; // [R06]
    assign cif.offset = s_q.offset;
    assign cif.mode = s_q.ctrl[CTRL_MODE_LO +: 2]; // [R08]

    aol_post i_aol_post (
        .clk(clk),
        .rstn(rstn),
        .p(cif.post)
    );

    assign cmpTrue = s_q.ctrl[CTRL_GT] ? (cif.result >= s_q.cmp) : (cif.result < s_q.cmp);

    // =======================================================
    // Sequencing and registers
    always_comb begin
        s_d = s_q;
        s_d.ack = wb_cyc_i & wb_stb_i & ~s_q.ack;
        s_d.trigPrev = trigSync[1];
        if (busRd) begin
            case (wb_adr_i)
                OFF_CTRL: s_d.rdata = {16'h0000, s_q.ctrl};
                OFF_STATUS: s_d.rdata = {29'h0, s_q.calFail, s_q.st != ST_IDLE, s_q.done};
                OFF_OFFSET: s_d.rdata = {16'h0000, s_q.offset};
                OFF_RESULT: s_d.rdata = {16'h0000, s_q.result};
                OFF_CMP: s_d.rdata = {16'h0000, s_q.cmp};
                default: s_d.rdata = 32'h00000000;
            endcase
        end
        if (busRd && wb_adr_i == OFF_RESULT) begin
            s_d.done = 1'b0;
        end
        // The start strobe lives one cycle, so it is cleared before a write may set it.
        s_d.ctrl[CTRL_SWSTART] = 1'b0;
        // Writes are ignored while calibration runs, matching the converter lockout.
        if (busWr && s_q.st != ST_CAL) begin
            case (wb_adr_i)
                OFF_CTRL: s_d.ctrl = merge(s_q.ctrl, wb_dat_i, wb_sel_i);
                OFF_OFFSET: s_d.offset = merge(s_q.offset, wb_dat_i, wb_sel_i); // [R05]
                OFF_CMP: s_d.cmp = merge(s_q.cmp, wb_dat_i, wb_sel_i);
                default: begin
                end
            endcase
        end
        if (!inStop) begin
            s_d.stopFirstHeld = 1'b0;
        end
        case (s_q.st)
            ST_IDLE: begin
                if (s_q.ctrl[CTRL_CAL]) begin
                    if (s_q.ctrl[CTRL_HWTRIG]) begin
                        s_d.ctrl[CTRL_CAL] = 1'b0;
                        s_d.calFail = 1'b1;
                    end else begin
                        s_d.st = ST_CAL;
                        s_d.cnt = CAL_CYCLES;
                        s_d.calFail = 1'b0;
                    end
                end else if (s_q.ctrl[CTRL_ENABLE] && ((s_q.ctrl[CTRL_HWTRIG] && trigEdge)
                    || (!sleeping && !s_q.ctrl[CTRL_HWTRIG] && s_q.ctrl[CTRL_SWSTART]))) begin // [R10]
                    s_d.st = ST_CONV;
                    s_d.cnt = CONV_CYCLES;
                    s_d.avgCnt = 6'h00;
                    s_d.acc = 22'h0;
                end
            end
            ST_CONV: begin
                if (s_q.cnt != 4'h0) begin
                    s_d.cnt = s_q.cnt - 4'h1; // [R09] [R11]
                end else if (cif.valid) begin
                    s_d.st = ST_POST;
                end else begin
                    s_d.acc = s_q.acc + 22'(sampleB);
                    s_d.avgCnt = s_q.avgCnt + 6'h01;
                    s_d.cnt = CONV_CYCLES;
                end
            end
            ST_POST: begin
                // A failing compare leaves the flag and result alone. [R12] [R13] [R19]
                if (!s_q.ctrl[CTRL_CMPEN] || cmpTrue) begin
                    if (!s_q.stopFirstHeld) begin
                        s_d.result = cif.result; // [R01] [R18]
                    end
                    if (inStop) begin
                        s_d.stopFirstHeld = 1'b1;
                    end
                    s_d.done = 1'b1;
                end
                if (s_q.ctrl[CTRL_CONT] && s_q.ctrl[CTRL_ENABLE]) begin
                    s_d.st = ST_CONV;
                    s_d.cnt = CONV_CYCLES;
                    s_d.avgCnt = 6'h00;
                    s_d.acc = 22'h0;
                end else begin
                    s_d.st = ST_IDLE;
                end
            end
            ST_CAL: begin
                if (inStop) begin
                    s_d.st = ST_IDLE;
                    s_d.ctrl[CTRL_CAL] = 1'b0;
                    s_d.calFail = 1'b1;
                end else if (s_q.cnt != 4'h0) begin
                    s_d.cnt = s_q.cnt - 4'h1;
                end else begin
                    s_d.st = ST_IDLE;
                    s_d.ctrl[CTRL_CAL] = 1'b0;
                    s_d.offset = CAL_OFFSET; // [R04]
                    s_d.done = 1'b1;
                end
            end
            default: s_d.st = ST_IDLE;
        endcase
        // Abort drops only the sequence; every register keeps its value. [R14] [R15] [R17]
        if (inStop && !s_q.ctrl[CTRL_ASYNC] && (s_q.st == ST_CONV || s_q.st == ST_POST)) begin
            s_d.st = ST_IDLE;
            s_d.done = s_q.done;
            s_d.result = s_q.result;
        end
        if (inLp) begin
            s_d = '0; // [R20] [R21]
            s_d.st = ST_IDLE;
            s_d.offset = OFFSET_RST;
            s_d.result = RESULT_RST;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
            s_q.st <= ST_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign wb_ack_o = s_q.ack;
    assign wb_dat_o = s_q.rdata;
    assign convIrq = s_q.done & s_q.ctrl[CTRL_IRQEN]; // [R23]

    // =======================================================
    // Checks
    sequence s_calEnd;
        s_q.st == ST_CAL && s_q.cnt == 4'h0 && !inStop && !inLp;
    endsequence
    property p_calLoad;
        @(posedge clk) disable iff (!rstn) s_calEnd |=> (s_q.offset == CAL_OFFSET && s_q.done);
    endproperty
    a_calLoad: assert property (p_calLoad) else $error("Calibration did not load offset."); // [R04]
    property p_lp;
        @(posedge clk) disable iff (!rstn)
            inLp |=> (s_q.st == ST_IDLE && s_q.ctrl == 16'h0000 && s_q.offset == OFFSET_RST && !convIrq);
    endproperty
    a_lp: assert property (p_lp) else $error("Low-power stop did not reset block."); // [R20]
    property p_irq;
        @(posedge clk) disable iff (!rstn)
            (s_q.st == ST_POST && (!s_q.ctrl[CTRL_CMPEN] || cmpTrue) && s_q.ctrl[CTRL_IRQEN] && !busWr
            && !inLp && !(inStop && !s_q.ctrl[CTRL_ASYNC])) |=> convIrq;
    endproperty
    a_irq: assert property (p_irq) else $error("Completed conversion raised no interrupt."); // [R23]
    property p_abort;
        @(posedge clk) disable iff (!rstn)
            (inStop && !inLp && !s_q.ctrl[CTRL_ASYNC] && s_q.st == ST_CONV) |=> (s_q.st == ST_IDLE);
    endproperty
    a_abort: assert property (p_abort) else $error("Stop did not abort conversion."); // [R14]
    property p_keep;
        @(posedge clk) disable iff (!rstn)
            (inStop && !inLp && !s_q.ctrl[CTRL_ASYNC] && s_q.st == ST_CONV) |=> $stable(s_q.result);
    endproperty
    a_keep: assert property (p_keep) else $error("Stop changed the result."); // [R15]
    property p_cmpFail;
        @(posedge clk) disable iff (!rstn)
            (s_q.st == ST_POST && s_q.ctrl[CTRL_CMPEN] && !cmpTrue && !inLp) |=> $stable(s_q.result);
    endproperty
    a_cmpFail: assert property (p_cmpFail) else $error("Failed compare stored a result."); // [R12]
    property p_post;
        @(posedge clk) disable iff (!rstn)
            (s_q.st == ST_POST && !s_q.ctrl[CTRL_CMPEN] && !s_q.stopFirstHeld && !inLp && !inStop)
            |=> (s_q.result == $past(cif.result) && s_q.done);
    endproperty
    a_post: assert property (p_post) else $error("Corrected result not stored."); // [R01]
    property p_wake;
        @(posedge clk) disable iff (!rstn)
            (s_q.st == ST_IDLE && sleeping && !s_q.ctrl[CTRL_HWTRIG] && !s_q.ctrl[CTRL_CAL] && !inLp)
            |=> (s_q.st != ST_CONV);
    endproperty
    a_wake: assert property (p_wake) else $error("Software start while asleep."); // [R10]
    // Ack lasts one cycle; a request still held in the cycle after it is taken again.
    property p_ackPulse;
        @(posedge clk) disable iff (!rstn) wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ackPulse: assert property (p_ackPulse) else $error("Acknowledge held longer than one cycle.");
    property p_swStart;
        @(posedge clk) disable iff (!rstn)
            (s_q.st == ST_IDLE && s_q.ctrl[CTRL_ENABLE] && s_q.ctrl[CTRL_SWSTART] && !s_q.ctrl[CTRL_HWTRIG]
            && !s_q.ctrl[CTRL_CAL] && !sleeping && !inLp) |=> (s_q.st == ST_CONV && !s_q.ctrl[CTRL_SWSTART]);
    endproperty
    a_swStart: assert property (p_swStart) else $error("Software start was not taken."); // [R16]
    sequence s_convEnd;
        s_q.st == ST_CONV && cif.valid && !inStop && !inLp;
    endsequence
    property p_convEnd;
        @(posedge clk) disable iff (!rstn) s_convEnd |=> (s_q.st == ST_POST);
    endproperty
    a_convEnd: assert property (p_convEnd) else $error("Finished conversion was not post-processed."); // [R09]
    logic [15:0] wrLow;
    assign wrLow = wb_dat_i[15:0];
    property p_ofsWrite;
        @(posedge clk) disable iff (!rstn)
            (busWr && wb_adr_i == OFF_OFFSET && wb_sel_i[1:0] == 2'h3 && s_q.st != ST_CAL && !inLp)
            |=> (s_q.offset == $past(wrLow));
    endproperty
    a_ofsWrite: assert property (p_ofsWrite) else $error("Offset write did not land."); // [R05]
endmodule

/* sim/aol_ctrl_tb.sv */
// Self-checking bench of the offset-correcting converter control block.
// Assumes aol_pkg and aol_ctrl are compiled first; the bench drives every port itself.
`timescale 1ns/1ps
module aol_ctrl_tb;
    import aol_pkg::*;
    // ==========================================================
    // Signals and clock
    typedef struct packed {
        logic [1:0] m;
        logic irq;
        logic [15:0] o;
        logic [15:0] r;
        logic [15:0] e;
    } aol_row_t;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
    logic [7:0] wbAdr = 8'h00;
    logic [31:0] wbDatI = 32'h0, wbDatO, rdv;
    logic wbAck, convIrq, ok;
    logic hwTrig = 1'b0, waitM = 1'b0, stopM = 1'b0, lpStop = 1'b0;
    logic [15:0] sample = 16'h0000;
    int errCount = 0;
    int nChecks = 0;
    aol_row_t rows [9] = '{
        '{MODE_8, 1'b1, 16'h0180, 16'h0010, 16'h000D},
        '{MODE_8, 1'b0, 16'h017F, 16'h0010, 16'h000E},
        '{MODE_8, 1'b1, 16'hFF80, 16'h00FF, 16'h00FF},
        '{MODE_8, 1'b1, 16'h0800, 16'h0005, 16'h0000},
        '{MODE_12, 1'b1, 16'h0100, 16'h0800, 16'h07F0},
        '{MODE_12, 1'b0, 16'hFFF0, 16'h0FFF, 16'h0FFF},
        '{MODE_10, 1'b1, 16'h0040, 16'h0200, 16'h01FF},
        '{MODE_10, 1'b1, 16'h8000, 16'h0300, 16'h03FF},
        '{MODE_12, 1'b1, 16'h7FF0, 16'h0100, 16'h0000}
    };
    always #25 clk = ~clk;
    aol_ctrl i_aol_ctrl (
        .clk(clk), .resetn(resetn), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
        .wb_adr_i(wbAdr), .wb_sel_i(4'h3), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO),
        .wb_ack_o(wbAck), .sampleIn(sample), .hwTrigger(hwTrig), .waitMode(waitM),
        .stopMode(stopM), .lowPowerStop(lpStop), .convIrq(convIrq)
    );
    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nChecks++;
        if (got !== exp) begin
            errCount++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= a;
        wbDatI <= d;
        @(posedge clk);
        while (wbAck !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        chk(32'(wbAck), 32'h1);
        q = wbDatO;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        xfer(1'b0, a, 32'h0, q);
    endtask
    function automatic logic [31:0] mk(input logic [1:0] m, input logic [31:0] b);
        return b | 32'h3 | (32'(m) << CTRL_MODE_LO);
    endfunction
    // Writes the offset and the raw code, then starts by software.
    task automatic start(input logic [31:0] ctl, input logic [15:0] ofs, input logic [15:0] raw);
        sample <= raw;
        wr(OFF_OFFSET, {16'h0, ofs});
        wr(OFF_CTRL, ctl);
    endtask
    task automatic waitDone(input int lim, output logic f);
        int n;
        n = 0;
        f = 1'b0;
        while (!f && n < lim) begin
            rd(OFF_STATUS, rdv);
            f = (rdv[STATUS_DONE] === 1'b1);
            n++;
        end
    endtask
    task automatic finishTest;
        $display("Checks %0d, mismatches %0d", nChecks, errCount);
        if (errCount == 0 && nChecks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // ==========================================================
    // Watchdog: the whole sequence needs about 900 cycles.
    initial begin
        repeat (20000) @(posedge clk);
        errCount++;
        finishTest();
    end
    // ==========================================================
    // Main sequence
    initial begin
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        rd(OFF_OFFSET, rdv);
        chk(rdv, {16'h0, OFFSET_RST});
        rd(OFF_RESULT, rdv);
        chk(rdv, {16'h0, RESULT_RST});
        rd(OFF_STATUS, rdv);
        chk(rdv, 32'h0);
        wr(8'hFC, 32'hFFFF);
        rd(8'hFC, rdv);
        chk(rdv, 32'h0);
        $display("Reset and unmapped test done");
        // Calibrate before any conversion; reading the result clears the done flag it leaves.
        wr(OFF_CTRL, 32'h1 | (32'h1 << CTRL_CAL));
        waitDone(40, ok);
        chk(32'(ok), 32'h1);
        rd(OFF_RESULT, rdv);
        chk(rdv, {16'h0, RESULT_RST});
        $display("Initial calibration test done");
        foreach (rows[i]) begin
            start(mk(rows[i].m, 32'(rows[i].irq) << CTRL_IRQEN), rows[i].o, rows[i].r);
            waitDone(40, ok);
            chk(32'(ok), 32'h1);
            chk(32'(convIrq), 32'(rows[i].irq));
            rd(OFF_RESULT, rdv);
            chk(rdv, {16'h0, rows[i].e});
            chk(32'(convIrq), 32'h0);
        end
        $display("Offset and saturation table done");
        // Averaging of four samples; the negative offset raises the result.
        start(mk(MODE_12, 32'h1 << CTRL_AVGEN), 16'hFFF0, 16'h0100);
        waitDone(80, ok);
        chk(32'(ok), 32'h1);
        rd(OFF_RESULT, rdv);
        chk(rdv, 32'h0101);
        $display("Averaging test done");
        // A failed compare leaves done clear and the converter idle.
        wr(OFF_CMP, 32'h0200);
        start(mk(MODE_12, (32'h1 << CTRL_CMPEN) | (32'h1 << CTRL_GT)), 16'h0000, 16'h0100);
        waitDone(15, ok);
        chk(32'(ok), 32'h0);
        chk({29'h0, rdv[2:0]}, 32'h0);
        start(mk(MODE_12, (32'h1 << CTRL_CMPEN) | (32'h1 << CTRL_GT)), 16'h0000, 16'h0300);
        waitDone(40, ok);
        chk(32'(ok), 32'h1);
        rd(OFF_RESULT, rdv);
        chk(rdv, 32'h0300);
        $display("Compare test done");
        // Wait mode: a running conversion ends, software start is refused, a trigger works.
        start(mk(MODE_12, 32'h0), 16'h0000, 16'h0123);
        waitM <= 1'b1;
        waitDone(40, ok);
        chk(32'(ok), 32'h1);
        rd(OFF_RESULT, rdv);
        chk(rdv, 32'h0123);
        sample <= 16'h0456;
        wr(OFF_CTRL, mk(MODE_12, 32'h0));
        waitDone(15, ok);
        chk(32'(ok), 32'h0);
        wr(OFF_CTRL, mk(MODE_12, 32'h1 << CTRL_HWTRIG));
        waitDone(15, ok);
        chk(32'(ok), 32'h0);
        hwTrig <= 1'b1;
        waitDone(40, ok);
        chk(32'(ok), 32'h1);
        rd(OFF_RESULT, rdv);
        chk(rdv, 32'h0456);
        hwTrig <= 1'b0;
        waitM <= 1'b0;
        $display("Wait mode test done");
        // Stop on the bus clock aborts; registers survive; a new start is needed.
        start(mk(MODE_12, 32'h0), 16'h0100, 16'h0200);
        stopM <= 1'b1;
        repeat (30) @(posedge clk);
        stopM <= 1'b0;
        repeat (4) @(posedge clk);
        rd(OFF_STATUS, rdv);
        chk(rdv, 32'h0);
        rd(OFF_RESULT, rdv);
        chk(rdv, 32'h0456);
        rd(OFF_OFFSET, rdv);
        chk(rdv, 32'h0100);
        wr(OFF_CTRL, mk(MODE_12, 32'h0));
        waitDone(40, ok);
        chk(32'(ok), 32'h1);
        rd(OFF_RESULT, rdv);
        chk(rdv, 32'h01F0);
        // With the asynchronous clock continuous conversions go on through stop; the first result is kept.
        start(mk(MODE_12, (32'h1 << CTRL_ASYNC) | (32'h1 << CTRL_CONT)), 16'h0000, 16'h0222);
        stopM <= 1'b1;
        waitDone(40, ok);
        chk(32'(ok), 32'h1);
        sample <= 16'h0333;
        repeat (60) @(posedge clk);
        rd(OFF_STATUS, rdv);
        chk({31'h0, rdv[STATUS_ACTIVE]}, 32'h1);
        rd(OFF_RESULT, rdv);
        chk(rdv, 32'h0222);
        stopM <= 1'b0;
        wr(OFF_CTRL, 32'h0);
        repeat (30) @(posedge clk);
        $display("Stop mode test done");
        // Calibration replaces a software offset; writes during it are dropped.
        wr(OFF_OFFSET, 32'h1234);
        rd(OFF_OFFSET, rdv);
        chk(rdv, 32'h1234);
        wr(OFF_CTRL, 32'h1 | (32'h1 << CTRL_CAL));
        wr(OFF_OFFSET, 32'h5555);
        repeat (30) @(posedge clk);
        rd(OFF_OFFSET, rdv);
        chk(rdv, {16'h0, CAL_OFFSET});
        $display("Calibration test done");
        // Low-power stop leaves every register at its reset value.
        wr(OFF_OFFSET, 32'h1234);
        wr(OFF_CTRL, 32'h1);
        lpStop <= 1'b1;
        repeat (6) @(posedge clk);
        lpStop <= 1'b0;
        repeat (4) @(posedge clk);
        rd(OFF_OFFSET, rdv);
        chk(rdv, {16'h0, OFFSET_RST});
        rd(OFF_CTRL, rdv);
        chk(rdv, 32'h0);
        $display("Low-power stop test done");
        finishTest();
    end
endmodule
